// File: pkg/ssos_cfg.svh
`ifndef SSOS_CFG_SVH
`define SSOS_CFG_SVH
// ****************************************
// timing
// ****************************************
`define SSOS_CLK_NS      5
`define SSOS_TICK_NS     1000000
// ****************************************
// outputs and function codes
// ****************************************
`define SSOS_NUM_OUT     6
`define SSOS_NUM_PIN     10
`define SSOS_FSEL_W      8
`define SSOS_FN_OFF      8'h00
`define SSOS_FN_RDY      8'h01
`define SSOS_FN_SON      8'h02
`define SSOS_FN_ZSP      8'h03
`define SSOS_FN_TSP      8'h04
`define SSOS_FN_POS      8'h05
`define SSOS_FN_TQL      8'h06
`define SSOS_FN_FLT      8'h07
`define SSOS_FN_BRK      8'h08
`define SSOS_FN_OLW      8'h10
`define SSOS_FN_WRN      8'h11
`define SSOS_FN_SOK      8'h19
// ****************************************
// register byte addresses
// ****************************************
`define SSOS_A_FSEL_LO   8'h00
`define SSOS_A_FSEL_HI   8'h04
`define SSOS_A_MODE      8'h08
`define SSOS_A_ZERO_SPD  8'h0C
`define SSOS_A_TGT_SPD   8'h10
`define SSOS_A_POS_RNG   8'h14
`define SSOS_A_SPD_TOL   8'h18
`define SSOS_A_OVL_MS    8'h1C
`define SSOS_A_OVL_PCT   8'h20
`define SSOS_A_BRK_ON    8'h24
`define SSOS_A_BRK_OFF   8'h28
`define SSOS_A_STATUS    8'h2C
`define SSOS_A_MASK      8'h30
`define SSOS_A_FLAGS     8'h34
// ****************************************
// status bit positions
// ****************************************
`define SSOS_ST_FLT      0
`define SSOS_ST_WRN      1
`define SSOS_ST_OLW      2
`define SSOS_ST_W        3
// ****************************************
// reset values
// ****************************************
`define SSOS_RST_FSEL    32'h00000000
`define SSOS_RST_ZERO    16'h000A
`define SSOS_RST_TGT     16'h0BB8
`define SSOS_RST_RNG     16'h0064
`define SSOS_RST_TOL     16'h000A
`define SSOS_RST_OVL_MS  16'h1F40
`define SSOS_RST_PCT     8'h64
`define SSOS_RST_DLY     16'h0000
`endif

// File: pkg/ssos_pkg.sv
package ssos_pkg;
  typedef enum logic [2:0] {
    SSOS_M_PT = 3'h0,
    SSOS_M_PR = 3'h1,
    SSOS_M_S  = 3'h2,
    SSOS_M_T  = 3'h3,
    SSOS_M_SZ = 3'h4,
    SSOS_M_TZ = 3'h5
  } ssos_mode_t;
  typedef enum logic [1:0] {
    SSOS_B_HOLD  = 2'b00,
    SSOS_B_WREL  = 2'b01,
    SSOS_B_FREE  = 2'b11,
    SSOS_B_WHOLD = 2'b10
  } ssos_brk_t;
endpackage

// File: design/ssos_brake.sv
`timescale 1ns/1ps
`include "ssos_cfg.svh"
module ssos_brake
  import ssos_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        tick,
  input  wire logic        run,
  input  wire logic [15:0] on_dly,
  input  wire logic [15:0] off_dly,
  output logic             release_o
);
  ssos_brk_t   st_r;
  logic [15:0] cnt_r;

  // ****************************************
  // brake sequencing, delays in ms ticks
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r  <= SSOS_B_HOLD;
      cnt_r <= 16'h0000;
    end else begin
      unique case (st_r)
        SSOS_B_HOLD: begin
          cnt_r <= 16'h0000;
          if (run) begin
            st_r <= (on_dly == 16'h0000) ? SSOS_B_FREE : SSOS_B_WREL;
          end
        end
        SSOS_B_WREL: begin
          if (!run) begin
            st_r <= SSOS_B_HOLD;
          end else if (tick) begin
            cnt_r <= cnt_r + 16'h0001;
            if (cnt_r + 16'h0001 >= on_dly) begin
              st_r <= SSOS_B_FREE;
            end
          end
        end
        SSOS_B_FREE: begin
          cnt_r <= 16'h0000;
          if (!run) begin
            st_r <= (off_dly == 16'h0000) ? SSOS_B_HOLD : SSOS_B_WHOLD;
          end
        end
        SSOS_B_WHOLD: begin
          if (run) begin
            st_r <= SSOS_B_FREE;
          end else if (tick) begin
            cnt_r <= cnt_r + 16'h0001;
            if (cnt_r + 16'h0001 >= off_dly) begin
              st_r <= SSOS_B_HOLD;
            end
          end
        end
      endcase
    end
  end

  // brake stays released through the off delay so the motor can slow first
  assign release_o = (st_r == SSOS_B_FREE) || (st_r == SSOS_B_WHOLD);

  a_brake_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == SSOS_B_HOLD && !run) |=> !release_o)
    else $error("brake released without enable");
  a_brake_quick: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == SSOS_B_HOLD && run && on_dly == 16'h0000) |=> release_o)
    else $error("brake not released with zero delay");
endmodule

// File: design/ssos_top.sv
`timescale 1ns/1ps
// ****************************************
// servo status output select
// ****************************************
// How it works
// - code 0x01: high while control and main power present and no alarm
// - code 0x02: high while servo enabled and no alarm
// - code 0x03: high while motor speed below zero-speed threshold
// - code 0x04: high while motor speed above target-speed threshold
// - code 0x05: in pulse position mode, high while deviation below range
// - code 0x06: high while torque limiting, never in torque modes
// - code 0x07: high on any alarm except limits, comm error, undervoltage
// - code 0x08: brake release signal with on and off delays
// - code 0x10: high once overload time exceeds allowable time times percent
// - overload time beyond allowable time raises overload alarm too
// - code 0x11: high on limit, comm error or undervoltage warnings
// - code 0x19: in speed modes, high while speed error below tolerance
`include "ssos_cfg.svh"
module ssos_top
  import ssos_pkg::*;
#(
  parameter int unsigned TICK_CYC = `SSOS_TICK_NS / `SSOS_CLK_NS
)(
  input  wire logic                     REF_CLK,
  input  wire logic                     RST_N,
  input  wire logic [7:0]               ADDR,
  input  wire logic [31:0]              WDATA,
  input  wire logic                     WR,
  input  wire logic                     RD,
  output logic      [31:0]              RDATA,
  input  wire logic                     CTRL_PWR,
  input  wire logic                     MAIN_PWR,
  input  wire logic                     SERVO_ON,
  input  wire logic                     EXT_ALARM,
  input  wire logic                     FWD_LIMIT,
  input  wire logic                     REV_LIMIT,
  input  wire logic                     COMM_ERR,
  input  wire logic                     UNDER_VOLT,
  input  wire logic                     TORQUE_LIM,
  input  wire logic                     OVERLOAD,
  input  wire logic signed [15:0]       SPEED_FB,
  input  wire logic signed [15:0]       SPEED_CMD,
  input  wire logic signed [31:0]       POS_DEV,
  output logic      [`SSOS_NUM_OUT-1:0] DO_OUT,
  output logic                          IRQ
);
  localparam int NO = `SSOS_NUM_OUT;
  localparam int NP = `SSOS_NUM_PIN;

  logic [NP-1:0]          pin_s1_r;
  logic [NP-1:0]          pin_s2_r;
  logic                   ctrl_s;
  logic                   main_s;
  logic                   son_s;
  logic                   alm_s;
  logic                   fwd_s;
  logic                   rev_s;
  logic                   com_s;
  logic                   uv_s;
  logic                   tql_s;
  logic                   ovl_s;
  logic [47:0]            fsel_r;
  ssos_mode_t             mode_r;
  logic [15:0]            zero_spd_r;
  logic [15:0]            tgt_spd_r;
  logic [15:0]            pos_rng_r;
  logic [15:0]            spd_tol_r;
  logic [15:0]            ovl_ms_r;
  logic [7:0]             ovl_pct_r;
  logic [15:0]            brk_on_r;
  logic [15:0]            brk_off_r;
  logic [`SSOS_ST_W-1:0]  status_r;
  logic [`SSOS_ST_W-1:0]  mask_r;
  logic [31:0]            rdata_r;
  logic [31:0]            tick_cnt_r;
  logic                   tick;
  logic [15:0]            acc_ms_r;
  logic [23:0]            acc_x100;
  logic [23:0]            warn_lim;
  logic                   ovl_alarm;
  logic                   olw_c;
  logic                   fault_c;
  logic                   warn_c;
  logic                   rdy_c;
  logic                   son_c;
  logic                   zsp_c;
  logic                   tsp_c;
  logic                   pos_c;
  logic                   tql_c;
  logic                   sok_c;
  logic                   brk_c;
  logic [32:0]            spd_mag;
  logic [32:0]            err_mag;
  logic [32:0]            dev_mag;
  logic                   speed_mode;
  logic                   torque_mode;
  logic [`SSOS_ST_W-1:0]  ev_prev_r;
  logic [`SSOS_ST_W-1:0]  ev_now;
  logic [`SSOS_ST_W-1:0]  ev_rise;
  logic                   st_clr;
  logic [NO-1:0]          do_r;
  logic [10:0]            flags;

  function automatic logic [32:0] mag(input logic signed [32:0] v);
    return (v < 0) ? 33'(-v) : 33'(v);
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= {CTRL_PWR, MAIN_PWR, SERVO_ON, EXT_ALARM, FWD_LIMIT,
                   REV_LIMIT, COMM_ERR, UNDER_VOLT, TORQUE_LIM, OVERLOAD};
      pin_s2_r <= pin_s1_r;
    end
  end
  assign {ctrl_s, main_s, son_s, alm_s, fwd_s, rev_s, com_s, uv_s, tql_s, ovl_s} = pin_s2_r;

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      fsel_r     <= {16'h0000, `SSOS_RST_FSEL};
      mode_r     <= SSOS_M_PT;
      zero_spd_r <= `SSOS_RST_ZERO;
      tgt_spd_r  <= `SSOS_RST_TGT;
      pos_rng_r  <= `SSOS_RST_RNG;
      spd_tol_r  <= `SSOS_RST_TOL;
      ovl_ms_r   <= `SSOS_RST_OVL_MS;
      ovl_pct_r  <= `SSOS_RST_PCT;
      brk_on_r   <= `SSOS_RST_DLY;
      brk_off_r  <= `SSOS_RST_DLY;
      mask_r     <= '0;
    end else if (WR) begin
      unique case (ADDR)
        `SSOS_A_FSEL_LO: fsel_r[31:0]  <= WDATA;
        `SSOS_A_FSEL_HI: fsel_r[47:32] <= WDATA[15:0];
        `SSOS_A_MODE:    mode_r        <= ssos_mode_t'(WDATA[2:0]);
        `SSOS_A_ZERO_SPD: zero_spd_r   <= WDATA[15:0];
        `SSOS_A_TGT_SPD: tgt_spd_r     <= WDATA[15:0];
        `SSOS_A_POS_RNG: pos_rng_r     <= WDATA[15:0];
        `SSOS_A_SPD_TOL: spd_tol_r     <= WDATA[15:0];
        `SSOS_A_OVL_MS:  ovl_ms_r      <= WDATA[15:0];
        `SSOS_A_OVL_PCT: ovl_pct_r     <= WDATA[7:0];
        `SSOS_A_BRK_ON:  brk_on_r      <= WDATA[15:0];
        `SSOS_A_BRK_OFF: brk_off_r     <= WDATA[15:0];
        `SSOS_A_MASK:    mask_r        <= WDATA[`SSOS_ST_W-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // register reads, data in the next cycle
  // ****************************************
  assign flags = {olw_c, ovl_alarm, warn_c, fault_c, brk_c, sok_c,
                  tql_c, pos_c, tsp_c, zsp_c, rdy_c};
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      rdata_r <= 32'h00000000;
    end else if (RD) begin
      unique case (ADDR)
        `SSOS_A_FSEL_LO: rdata_r <= fsel_r[31:0];
        `SSOS_A_FSEL_HI: rdata_r <= {16'h0000, fsel_r[47:32]};
        `SSOS_A_MODE:    rdata_r <= {29'h00000000, mode_r};
        `SSOS_A_ZERO_SPD: rdata_r <= {16'h0000, zero_spd_r};
        `SSOS_A_TGT_SPD: rdata_r <= {16'h0000, tgt_spd_r};
        `SSOS_A_POS_RNG: rdata_r <= {16'h0000, pos_rng_r};
        `SSOS_A_SPD_TOL: rdata_r <= {16'h0000, spd_tol_r};
        `SSOS_A_OVL_MS:  rdata_r <= {16'h0000, ovl_ms_r};
        `SSOS_A_OVL_PCT: rdata_r <= {24'h000000, ovl_pct_r};
        `SSOS_A_BRK_ON:  rdata_r <= {16'h0000, brk_on_r};
        `SSOS_A_BRK_OFF: rdata_r <= {16'h0000, brk_off_r};
        `SSOS_A_STATUS:  rdata_r <= {29'h00000000, status_r};
        `SSOS_A_MASK:    rdata_r <= {29'h00000000, mask_r};
        `SSOS_A_FLAGS:   rdata_r <= {10'h000, do_r, 5'h00, flags};
        default:         rdata_r <= 32'h00000000;
      endcase
    end else begin
      rdata_r <= 32'h00000000;
    end
  end
  assign RDATA = rdata_r;

  // ****************************************
  // millisecond tick and overload timer
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      tick_cnt_r <= 32'h00000000;
    end else begin
      tick_cnt_r <= tick ? 32'h00000000 : tick_cnt_r + 32'h00000001;
    end
  end
  assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));

  // overload time leaks away at the same rate once the load drops
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      acc_ms_r <= 16'h0000;
    end else if (tick) begin
      if (ovl_s && acc_ms_r != 16'hFFFF) begin
        acc_ms_r <= acc_ms_r + 16'h0001;
      end else if (!ovl_s && acc_ms_r != 16'h0000) begin
        acc_ms_r <= acc_ms_r - 16'h0001;
      end
    end
  end
  assign acc_x100  = {8'h00, acc_ms_r} * 24'h000064;
  assign warn_lim  = {8'h00, ovl_ms_r} * {16'h0000, ovl_pct_r};
  assign olw_c     = acc_x100 > warn_lim;
  assign ovl_alarm = acc_ms_r > ovl_ms_r;

  // ****************************************
  // conditions
  // ****************************************
  assign speed_mode  = (mode_r == SSOS_M_S) || (mode_r == SSOS_M_SZ);
  assign torque_mode = (mode_r == SSOS_M_T) || (mode_r == SSOS_M_TZ);
  assign spd_mag = mag(33'(SPEED_FB));
  assign err_mag = mag(33'(SPEED_FB) - 33'(SPEED_CMD));
  assign dev_mag = mag(33'(POS_DEV));
  // warnings are kept out of the alarm so a limit hit does not drop ready
  assign fault_c = alm_s || ovl_alarm;
  assign warn_c  = fwd_s || rev_s || com_s || uv_s;
  assign rdy_c   = ctrl_s && main_s && !fault_c;
  assign son_c   = son_s && !fault_c;
  assign zsp_c   = spd_mag < {17'h00000, zero_spd_r};
  assign tsp_c   = spd_mag > {17'h00000, tgt_spd_r};
  assign pos_c   = (mode_r == SSOS_M_PT) && (dev_mag < {17'h00000, pos_rng_r});
  assign tql_c   = tql_s && !torque_mode;
  assign sok_c   = speed_mode && (err_mag < {17'h00000, spd_tol_r});

  ssos_brake u_brake (
    .clk       (REF_CLK),
    .rst_n     (RST_N),
    .tick      (tick),
    .run       (son_c),
    .on_dly    (brk_on_r),
    .off_dly   (brk_off_r),
    .release_o (brk_c)
  );

  // ****************************************
  // output select, one per pin
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NO; gi++) begin : g_out
      logic [7:0] fn;
      assign fn = fsel_r[gi*8 +: 8];
      always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
          do_r[gi] <= 1'b0;
        end else begin
          unique case (fn)
            `SSOS_FN_RDY: do_r[gi] <= rdy_c;
            `SSOS_FN_SON: do_r[gi] <= son_c;
            `SSOS_FN_ZSP: do_r[gi] <= zsp_c;
            `SSOS_FN_TSP: do_r[gi] <= tsp_c;
            `SSOS_FN_POS: do_r[gi] <= pos_c;
            `SSOS_FN_TQL: do_r[gi] <= tql_c;
            `SSOS_FN_FLT: do_r[gi] <= fault_c;
            `SSOS_FN_BRK: do_r[gi] <= brk_c;
            `SSOS_FN_OLW: do_r[gi] <= olw_c;
            `SSOS_FN_WRN: do_r[gi] <= warn_c;
            `SSOS_FN_SOK: do_r[gi] <= sok_c;
            default:      do_r[gi] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate
  assign DO_OUT = do_r;

  // ****************************************
  // interrupts
  // ****************************************
  assign ev_now  = {olw_c, warn_c, fault_c};
  assign ev_rise = ev_now & ~ev_prev_r;
  assign st_clr  = RD && (ADDR == `SSOS_A_STATUS);
  // a rise in the clearing read cycle survives the clear
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ev_prev_r <= '0;
      status_r  <= '0;
    end else begin
      ev_prev_r <= ev_now;
      status_r  <= (st_clr ? '0 : status_r) | ev_rise;
    end
  end
  assign IRQ = |(status_r & mask_r);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  a_ready_level: assert property ($stable(fsel_r[7:0]) && fsel_r[7:0] == `SSOS_FN_RDY
    |=> DO_OUT[0] == $past(ctrl_s && main_s && !alm_s && !ovl_alarm))
    else $error("ready output wrong");
  a_enable_level: assert property (fsel_r[15:8] == `SSOS_FN_SON && alm_s
    |=> !DO_OUT[1])
    else $error("enable output high during alarm");
  a_zero_speed: assert property (fsel_r[47:40] == `SSOS_FN_ZSP && SPEED_FB == 16'sh0000
    && zero_spd_r != 16'h0000 |=> DO_OUT[5])
    else $error("zero speed output low at standstill");
  a_target_speed: assert property (fsel_r[15:8] == `SSOS_FN_TSP && SPEED_FB == tgt_spd_r
    |=> !DO_OUT[1])
    else $error("target speed output high at threshold");
  a_in_position: assert property (fsel_r[23:16] == `SSOS_FN_POS && mode_r != SSOS_M_PT
    |=> !DO_OUT[2])
    else $error("in position output outside pulse mode");
  a_torque_mode: assert property (fsel_r[39:32] == `SSOS_FN_TQL && torque_mode
    |=> !DO_OUT[4])
    else $error("torque limit output in torque mode");
  a_fault_warn: assert property (fsel_r[23:16] == `SSOS_FN_FLT && !alm_s && !ovl_alarm
    |=> !DO_OUT[2])
    else $error("fault output set by warning");
  a_warn_level: assert property (fsel_r[31:24] == `SSOS_FN_WRN && (fwd_s || uv_s)
    |=> DO_OUT[3])
    else $error("warning output missing");
  a_speed_ok: assert property (fsel_r[31:24] == `SSOS_FN_SOK && !speed_mode
    |=> !DO_OUT[3])
    else $error("speed reached outside speed mode");
  a_off_code: assert property ((fsel_r[7:0] == `SSOS_FN_OFF) [*2] |-> !DO_OUT[0])
    else $error("unused output active");
  a_ovl_order: assert property (ovl_alarm && ovl_pct_r <= 8'h64 |-> olw_c)
    else $error("overload alarm without warning");
  a_warn_pct: assert property (fsel_r[7:0] == `SSOS_FN_OLW && acc_ms_r == 16'h0000
    |=> !DO_OUT[0])
    else $error("early warning without overload time");
  a_irq_level: assert property ($rose(fault_c) && mask_r[`SSOS_ST_FLT] |=> IRQ [*1])
    else $error("interrupt not raised");
  a_no_latch: assert property (fsel_r[31:24] == `SSOS_FN_WRN && $fell(warn_c)
    && $stable(fsel_r[31:24]) |=> !DO_OUT[3])
    else $error("output latched");

  c_fault: cover property (fault_c ##1 DO_OUT[0]);
  c_brake: cover property ($rose(brk_c));
  c_olw:   cover property ($rose(olw_c));
  c_irq:   cover property ($rose(IRQ) ##[1:20] st_clr);
endmodule

// File: tb/ssos_ctrl_model.sv
`timescale 1ns/1ps
`include "ssos_cfg.svh"
// ****************************************
// motion controller sampling the status levels
// ****************************************
// it only samples, never drives: the status pins are levels
// and carry no handshake, so one flop per pin mirrors what
// the controller sees one cycle late
module ssos_ctrl_model (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic [`SSOS_NUM_OUT-1:0] do_in,
  output logic      [`SSOS_NUM_OUT-1:0] seen,
  output logic      [15:0]              toggles
);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seen <= '0;
    end else begin
      seen <= do_in;
    end
  end
  // counts level changes; a latched level would show too few
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      toggles <= 16'h0000;
    end else if (seen != do_in) begin
      toggles <= toggles + 16'h0001;
    end
  end
endmodule

// File: tb/servo_status_output_select_test.sv
`timescale 1ns/1ps
`include "ssos_cfg.svh"
module servo_status_output_select_test;
  import ssos_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  localparam int TICK = 10;
  logic REF_CLK, RST_N, WR, RD, CTRL_PWR, MAIN_PWR, SERVO_ON, EXT_ALARM;
  logic FWD_LIMIT, REV_LIMIT, COMM_ERR, UNDER_VOLT, TORQUE_LIM, OVERLOAD, IRQ;
  logic [7:0] ADDR;
  logic [31:0] WDATA, RDATA;
  logic signed [15:0] SPEED_FB, SPEED_CMD;
  logic signed [31:0] POS_DEV;
  logic [5:0] DO_OUT, seen;
  int n_fail;
  int tests_run;
  ssos_top #(.TICK_CYC(TICK)) dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .CTRL_PWR(CTRL_PWR), .MAIN_PWR(MAIN_PWR), .SERVO_ON(SERVO_ON),
    .EXT_ALARM(EXT_ALARM), .FWD_LIMIT(FWD_LIMIT), .REV_LIMIT(REV_LIMIT), .COMM_ERR(COMM_ERR),
    .UNDER_VOLT(UNDER_VOLT), .TORQUE_LIM(TORQUE_LIM), .OVERLOAD(OVERLOAD), .SPEED_FB(SPEED_FB),
    .SPEED_CMD(SPEED_CMD), .POS_DEV(POS_DEV), .DO_OUT(DO_OUT), .IRQ(IRQ));
  ssos_ctrl_model ctrl (.clk(REF_CLK), .rst_n(RST_N), .do_in(DO_OUT), .seen(seen), .toggles());
  initial begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end
  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge REF_CLK);
    WR <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge REF_CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge REF_CLK);
    RD <= 1'b0;
    #1;
    chk(what, exp, RDATA);
  endtask
  task automatic codes(input logic [47:0] c);
    wr(`SSOS_A_FSEL_LO, c[31:0]);
    wr(`SSOS_A_FSEL_HI, {16'h0000, c[47:32]});
  endtask
  // 3 edges from pin to output plus the controller's own flop
  task automatic dchk(input string what, input logic [5:0] exp);
    cyc(5);
    chk(what, {26'h0, exp}, {26'h0, seen});
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ****************************************
  // sequence
  // ****************************************
  logic [7:0] ra [13] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28,
                          8'h30, 8'h40};
  logic [31:0] rv [13] = '{32'h0, 32'h0, 32'h0, 32'h0000000A, 32'h00000BB8, 32'h00000064, 32'h0000000A,
                           32'h00001F40, 32'h00000064, 32'h0, 32'h0, 32'h0, 32'h0};
  logic signed [15:0] fbv [7] = '{16'h0009, 16'h000A, 16'hFFF7, 16'hFFF6, 16'h0BB8, 16'h0BB9, 16'hF447};
  logic signed [31:0] dv [4] = '{32'h00000063, 32'h00000064, 32'hFFFFFF9D, 32'hFFFFFF9C};
  logic signed [15:0] cv [4] = '{16'h006D, 16'h006E, 16'h005B, 16'h005A};
  initial begin
    int i;
    int m;
    int a;
    n_fail = 0;
    tests_run = 0;
    {RST_N, WR, RD, CTRL_PWR, MAIN_PWR, SERVO_ON, EXT_ALARM, FWD_LIMIT, REV_LIMIT} = 9'h000;
    {COMM_ERR, UNDER_VOLT, TORQUE_LIM, OVERLOAD} = 4'h0;
    {ADDR, WDATA, SPEED_FB, SPEED_CMD, POS_DEV} = '0;
    cyc(8);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    #1;
    chk("out after reset", 32'h0, {25'h0, DO_OUT, IRQ});
    wr(8'h40, 32'hFFFFFFFF);
    for (i = 0; i < 13; i++) rchk("reset value", ra[i], rv[i]);
    codes({8'h1F, 40'h0});
    {CTRL_PWR, MAIN_PWR, SERVO_ON, EXT_ALARM, FWD_LIMIT, TORQUE_LIM} <= 6'h3F;
    dchk("unused code", 6'h00);
    {EXT_ALARM, FWD_LIMIT, TORQUE_LIM, SERVO_ON} <= 4'h0;
    codes({`SSOS_FN_ZSP, `SSOS_FN_TQL, `SSOS_FN_WRN, `SSOS_FN_FLT, `SSOS_FN_SON, `SSOS_FN_RDY});
    dchk("powered", 6'h21);
    SERVO_ON <= 1'b1;
    dchk("enabled", 6'h23);
    MAIN_PWR <= 1'b0;
    dchk("main off", 6'h22);
    {MAIN_PWR, EXT_ALARM} <= 2'b11;
    dchk("alarm", 6'h24);
    EXT_ALARM <= 1'b0;
    dchk("alarm gone", 6'h23);
    for (i = 0; i < 4; i++) begin
      {FWD_LIMIT, REV_LIMIT, COMM_ERR, UNDER_VOLT} <= 4'h1 << i;
      dchk("warning", 6'h2B);
    end
    {FWD_LIMIT, TORQUE_LIM} <= 2'b01;
    for (m = 0; m < 6; m++) begin
      wr(`SSOS_A_MODE, m);
      dchk("torque limit", (m == 3 || m == 5) ? 6'h23 : 6'h33);
    end
    TORQUE_LIM <= 1'b0;
    wr(`SSOS_A_MODE, 32'h0);
    codes({16'h0, `SSOS_FN_SOK, `SSOS_FN_POS, `SSOS_FN_TSP, `SSOS_FN_ZSP});
    for (i = 0; i < 7; i++) begin
      SPEED_FB <= fbv[i];
      SPEED_CMD <= fbv[i];
      a = (fbv[i] < 0) ? -fbv[i] : fbv[i];
      dchk("speed", {4'b0001, a > 3000, a < 10});
    end
    for (i = 0; i < 4; i++) begin
      POS_DEV <= dv[i];
      dchk("position", {3'b000, i[0] == 1'b0, 1'b1, 1'b0});
    end
    {SPEED_FB, POS_DEV} <= {16'h0064, 32'h0};
    for (m = 0; m < 6; m++) begin
      wr(`SSOS_A_MODE, m);
      for (i = 0; i < 4; i++) begin
        SPEED_CMD <= cv[i];
        dchk("speed ok", {2'b00, (m == 2 || m == 4) && i[0] == 1'b0, m == 0, 2'b00});
      end
    end
    wr(`SSOS_A_MODE, 32'h0);
    codes({32'h0, `SSOS_FN_FLT, `SSOS_FN_RDY});
    rchk("flags", `SSOS_A_FLAGS, 32'h00010049);
    wr(`SSOS_A_STATUS, 32'h0);
    rchk("status clear", `SSOS_A_STATUS, 32'h00000003);
    wr(`SSOS_A_MASK, 32'h00000001);
    EXT_ALARM <= 1'b1;
    dchk("irq alarm", 6'h02);
    chk("irq set", 32'h1, {31'h0, IRQ});
    rchk("status", `SSOS_A_STATUS, 32'h00000001);
    chk("irq clear", 32'h0, {31'h0, IRQ});
    {EXT_ALARM, FWD_LIMIT} <= 2'b01;
    dchk("masked", 6'h01);
    chk("irq masked", 32'h0, {31'h0, IRQ});
    rchk("status warn", `SSOS_A_STATUS, 32'h00000002);
    FWD_LIMIT <= 1'b0;
    // brake: one tick of slack on the on delay and two on the off delay, the first tick may be partial
    codes({40'h0, `SSOS_FN_BRK});
    wr(`SSOS_A_BRK_ON, 32'h3);
    wr(`SSOS_A_BRK_OFF, 32'h2);
    SERVO_ON <= 1'b0;
    cyc(40);
    dchk("brake held", 6'h00);
    SERVO_ON <= 1'b1;
    dchk("brake early", 6'h00);
    cyc(40);
    chk("brake released", 32'h1, {26'h0, seen});
    SERVO_ON <= 1'b0;
    dchk("brake off delay", 6'h01);
    cyc(40);
    chk("brake engaged", 32'h0, {26'h0, seen});
    SERVO_ON <= 1'b1;
    codes({24'h0, `SSOS_FN_RDY, `SSOS_FN_FLT, `SSOS_FN_OLW});
    wr(`SSOS_A_OVL_MS, 32'hA);
    wr(`SSOS_A_OVL_PCT, 32'h32);
    OVERLOAD <= 1'b1;
    cyc(40);
    chk("overload early", 32'h4, {26'h0, seen});
    cyc(45);
    chk("overload warning", 32'h5, {26'h0, seen});
    cyc(55);
    chk("overload alarm", 32'h3, {26'h0, seen});
    OVERLOAD <= 1'b0;
    cyc(220);
    chk("overload decayed", 32'h4, {26'h0, seen});
    end_of_test;
  end
  initial begin
    cyc(30000);
    n_fail++;
    end_of_test;
  end
endmodule
